/* File: rtl/duty_cycle_pkg.sv */
// Shared constants and types for the listen-mode duty cycler
package duty_cycle_pkg;

  // --------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------
  localparam logic [5:0] IDX_OP_MODE = 6'h01;
  localparam logic [5:0] IDX_OSC_CAL = 6'h0a;
  localparam logic [5:0] IDX_DUTY_CFG = 6'h0d;
  localparam logic [5:0] IDX_IDLE_LEN = 6'h0e;
  localparam logic [5:0] IDX_RX_LEN = 6'h0f;
  localparam logic [5:0] IDX_REVISION = 6'h10;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int OP_ENABLE_BIT = 6;
  localparam int OP_ABORT_BIT = 5;
  localparam int OP_MODE_LSB = 2;
  localparam int CAL_TRIGGER_BIT = 7;
  localparam int CAL_DONE_BIT = 6;
  localparam int EV_ACCEPT = 0;
  localparam int EV_MISS = 1;
  localparam int EV_HALT = 2;
  localparam int EV_CAL = 3;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [7:0] DUTY_CFG_RESET = 8'h52;
  localparam logic [7:0] IDLE_LEN_RESET = 8'hf5;
  localparam logic [7:0] RX_LEN_RESET = 8'h20;
  localparam logic [2:0] MODE_RESET = 3'h1;
  localparam logic [5:0] OSC_LOW_BITS = 6'h01;
  // Arbitrary neutral revision code
  localparam logic [7:0] REVISION_CODE = 8'h13;

  // --------------------------------------------------------------
  // Operating modes and actions
  // --------------------------------------------------------------
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;
  localparam logic [1:0] ACT_STAY_RX = 2'h0;
  localparam logic [1:0] ACT_GOTO_MODE = 2'h1;
  localparam logic [1:0] ACT_RESUME = 2'h2;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_64US_NS = 64000;
  localparam int TICK_4MS_NS = 4100000;
  localparam int TICK_262MS_NS = 262000000;
  localparam int TICK_64US_CYC = TICK_64US_NS / CLK_PERIOD_NS;
  localparam int TICK_4MS_CYC = TICK_4MS_NS / CLK_PERIOD_NS;
  localparam int TICK_262MS_CYC = TICK_262MS_NS / CLK_PERIOD_NS;
  localparam int CAL_TIME_NS = 10000;
  localparam logic [11:0] CAL_CYC = 12'(CAL_TIME_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic [1:0] idle_tick_select;
    logic [1:0] rx_tick_select;
    logic wake_accept_rule;
    logic [1:0] after_accept_action;
    logic unused;
  } duty_cfg_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_IDLE = 3'h1,
    ST_RX = 3'h3,
    ST_WAIT = 3'h2,
    ST_HALT_RX = 3'h6,
    ST_HALT = 3'h7
  } seq_state_t;

endpackage : duty_cycle_pkg

/* File: rtl/tick_divider.sv */
// Resolution tick generator: 64 us, 4.1 ms and 262 ms enables
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned DIV_64US = duty_cycle_pkg::TICK_64US_CYC,
  parameter int unsigned DIV_4MS = duty_cycle_pkg::TICK_4MS_CYC,
  parameter int unsigned DIV_262MS = duty_cycle_pkg::TICK_262MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  output logic [2:0] tick_o
);
  localparam logic [24:0] LIMIT [3] = '{
    25'(DIV_64US - 1), 25'(DIV_4MS - 1), 25'(DIV_262MS - 1)};

  // Restart aligns every tick to the start of a phase, so the first
  // tick of a phase is a whole resolution step long.
  for (genvar g = 0; g < 3; g++) begin : g_div
    logic [24:0] cnt;
    logic [24:0] next_cnt;
    logic tick;
    logic next_tick;

    always_comb begin
      next_cnt = cnt + 25'h1;
      next_tick = 1'b0;
      if (restart_i) begin
        next_cnt = 25'h0;
      end else if (cnt >= LIMIT[g]) begin
        next_cnt = 25'h0;
        next_tick = 1'b1;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt <= 25'h0;
        tick <= 1'b0;
      end else begin
        cnt <= next_cnt;
        tick <= next_tick;
      end
    end

    assign tick_o[g] = tick;
  end

endmodule : tick_divider

/* File: rtl/listen_mode_duty_cycler.sv */
// Listen-mode duty cycler with APB register file
//
// Function
// [RQ1] Idle tick from 2-bit select: 64 us, 4.1 ms, 262 ms; 00 reserved.
// [RQ2] Receive tick from its own 2-bit select, same encoding.
// [RQ3] Accept on signal level; with rule bit set also need sync match.
// [RQ4] Action 00: stay in receive, stop cycling; software clears enable.
// [RQ5] Action 01: wait payload or timeout, then programmed mode, stop.
// [RQ6] Action 10: wait payload or timeout, then resume idle phase.
// [RQ7] Action 10: receive buffer discarded at next receive wake-up.
// [RQ8] Idle phase lasts idle count times idle tick; resets to f5.
// [RQ9] Receive phase lasts receive count times receive tick; resets 20.
// [RQ10] Read-only revision: full revision high nibble, mask low nibble.
// [RQ11] Enable bit starts cycling, clearing stops; set only in standby. The code accepts the enable bit with any mode field.
// [RQ12] Abort with enable cleared terminates cycling; abort reads zero.
// [RQ13] 3-bit mode field: sleep, standby, synth, transmit, receive.
// [RQ14] Calibration trigger starts calibration; done reads 0 meanwhile.
// [RQ15] While enabled, alternate idle and receive, idle first.
// [RQ16] No acceptance by receive end: back to idle, count restarts.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module listen_mode_duty_cycler #(
  parameter int unsigned DIV_64US = duty_cycle_pkg::TICK_64US_CYC,
  parameter int unsigned DIV_4MS = duty_cycle_pkg::TICK_4MS_CYC,
  parameter int unsigned DIV_262MS = duty_cycle_pkg::TICK_262MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic signal_level_above_i,
  input wire logic sync_word_match_i,
  input wire logic payload_complete_flag_i,
  input wire logic rx_timeout_i,
  output logic [2:0] chip_mode_o,
  output logic rx_buffer_clear_o,
  output logic irq_o
);
  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  duty_cycle_pkg::duty_cfg_t cfg, next_cfg;
  duty_cycle_pkg::seq_state_t state, next_state;
  logic [7:0] idle_len, next_idle_len, rx_len, next_rx_len;
  logic [2:0] mode_field, next_mode_field;
  logic enable, next_enable;
  logic cal_busy, next_cal_busy;
  logic [11:0] cal_cnt, next_cal_cnt;
  logic [3:0] status, next_status, mask, next_mask, events;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic [7:0] phase_cnt, next_phase_cnt;
  logic discard_pending, next_discard_pending;
  logic next_clear, restart, abort_req, accept, phase_end;
  logic [2:0] next_chip_mode, ticks;
  logic idle_tick, rx_tick, ev_accept, ev_miss, ev_halt, ev_cal;
  logic done, wr, rd;
  logic [5:0] idx;

  function automatic logic addr_ok(input logic [7:0] a);
    logic [5:0] i;
    i = a[7:2];
    return (a[1:0] == 2'h0) && (i == duty_cycle_pkg::IDX_OP_MODE ||
      i == duty_cycle_pkg::IDX_OSC_CAL || i == duty_cycle_pkg::IDX_DUTY_CFG ||
      i == duty_cycle_pkg::IDX_IDLE_LEN || i == duty_cycle_pkg::IDX_RX_LEN ||
      i == duty_cycle_pkg::IDX_REVISION ||
      i == duty_cycle_pkg::IDX_IRQ_STATUS ||
      i == duty_cycle_pkg::IDX_IRQ_MASK);
  endfunction : addr_ok

  // Maps a 2-bit resolution select onto the tick vector; 00 never ticks
  function automatic logic pick_tick(input logic [1:0] s,
                                     input logic [2:0] t);
    return (s == 2'h0) ? 1'b0 : t[s - 2'h1];
  endfunction : pick_tick

  // --------------------------------------------------------------
  // Resolution ticks
  // --------------------------------------------------------------
  tick_divider #(
    .DIV_64US(DIV_64US),
    .DIV_4MS(DIV_4MS),
    .DIV_262MS(DIV_262MS)
  ) u_ticks (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .tick_o(ticks)
  );

  // [RQ1] idle tick select
  assign idle_tick = pick_tick(cfg.idle_tick_select, ticks);
  // [RQ2] receive tick select
  assign rx_tick = pick_tick(cfg.rx_tick_select, ticks);

  // --------------------------------------------------------------
  // APB register file
  // --------------------------------------------------------------
  // One wait state: pready rises in the second access cycle so that
  // read data also leaves a flip-flop.
  assign done = psel_i && penable_i && pready_o;
  assign wr = done && pwrite_i && addr_ok(paddr_i);
  assign rd = done && !pwrite_i && addr_ok(paddr_i);
  assign idx = paddr_i[7:2];
  // [RQ12] abort only together with enable cleared
  assign abort_req = wr && idx == duty_cycle_pkg::IDX_OP_MODE &&
    !pwdata_i[duty_cycle_pkg::OP_ENABLE_BIT] &&
    pwdata_i[duty_cycle_pkg::OP_ABORT_BIT];
  assign events = {ev_cal, ev_halt, ev_miss, ev_accept};

  always_comb begin
    next_cfg = cfg;
    next_idle_len = idle_len;
    next_rx_len = rx_len;
    next_mode_field = mode_field;
    next_enable = enable;
    next_mask = mask;
    next_cal_busy = cal_busy;
    next_cal_cnt = cal_cnt;
    next_pready = psel_i && penable_i && !pready_o;
    next_pslverr = psel_i && penable_i && !pready_o && !addr_ok(paddr_i);
    next_prdata = 32'h0;
    ev_cal = 1'b0;
    if (cal_busy) begin
      next_cal_cnt = cal_cnt - 12'h1;
      if (cal_cnt == 12'h1) begin
        next_cal_busy = 1'b0;
        ev_cal = 1'b1;
      end
    end
    if (wr) begin
      case (idx)
        duty_cycle_pkg::IDX_OP_MODE: begin
          // [RQ11] enable bit
          next_enable = pwdata_i[duty_cycle_pkg::OP_ENABLE_BIT];
          // [RQ13] mode field
          next_mode_field = pwdata_i[duty_cycle_pkg::OP_MODE_LSB +: 3];
        end
        duty_cycle_pkg::IDX_OSC_CAL: begin
          // [RQ14] calibration trigger
          if (pwdata_i[duty_cycle_pkg::CAL_TRIGGER_BIT] && !cal_busy) begin
            next_cal_busy = 1'b1;
            next_cal_cnt = duty_cycle_pkg::CAL_CYC;
          end
        end
        duty_cycle_pkg::IDX_DUTY_CFG: begin
          next_cfg = pwdata_i[7:0];
          next_cfg.unused = 1'b0;
        end
        duty_cycle_pkg::IDX_IDLE_LEN: next_idle_len = pwdata_i[7:0];
        duty_cycle_pkg::IDX_RX_LEN: next_rx_len = pwdata_i[7:0];
        duty_cycle_pkg::IDX_IRQ_MASK: next_mask = pwdata_i[3:0];
        default: ;
      endcase
    end
    if (next_pready && !pwrite_i) begin
      case (idx)
        duty_cycle_pkg::IDX_OP_MODE:
          // [RQ12] abort reads zero
          next_prdata[7:0] = {1'b0, enable, 1'b0, chip_mode_o, 2'h0};
        duty_cycle_pkg::IDX_OSC_CAL:
          next_prdata[7:0] = {1'b0, !cal_busy, duty_cycle_pkg::OSC_LOW_BITS};
        duty_cycle_pkg::IDX_DUTY_CFG: next_prdata[7:0] = cfg;
        duty_cycle_pkg::IDX_IDLE_LEN: next_prdata[7:0] = idle_len;
        duty_cycle_pkg::IDX_RX_LEN: next_prdata[7:0] = rx_len;
        // [RQ10] revision code
        duty_cycle_pkg::IDX_REVISION:
          next_prdata[7:0] = duty_cycle_pkg::REVISION_CODE;
        duty_cycle_pkg::IDX_IRQ_STATUS: next_prdata[3:0] = status;
        duty_cycle_pkg::IDX_IRQ_MASK: next_prdata[3:0] = mask;
        default: ;
      endcase
    end
    // Read clears status; a new event in that same cycle survives
    next_status = status;
    if (rd && idx == duty_cycle_pkg::IDX_IRQ_STATUS) begin
      next_status = 4'h0;
    end
    next_status = next_status | events;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= duty_cycle_pkg::DUTY_CFG_RESET;
      // [RQ8] idle length reset
      idle_len <= duty_cycle_pkg::IDLE_LEN_RESET;
      // [RQ9] receive length reset
      rx_len <= duty_cycle_pkg::RX_LEN_RESET;
      mode_field <= duty_cycle_pkg::MODE_RESET;
      enable <= 1'b0;
      mask <= 4'h0;
      status <= 4'h0;
      cal_busy <= 1'b0;
      cal_cnt <= 12'h0;
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      cfg <= next_cfg;
      idle_len <= next_idle_len;
      rx_len <= next_rx_len;
      mode_field <= next_mode_field;
      enable <= next_enable;
      mask <= next_mask;
      status <= next_status;
      cal_busy <= next_cal_busy;
      cal_cnt <= next_cal_cnt;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      irq_o <= next_irq;
    end
  end

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  // [RQ3] acceptance criterion
  assign accept = signal_level_above_i &&
    (!cfg.wake_accept_rule || sync_word_match_i);
  // A zero coefficient ends the phase at its first tick
  assign phase_end = ({1'b0, phase_cnt} + 9'h1) >=
    {1'b0, (state == duty_cycle_pkg::ST_IDLE) ? idle_len : rx_len};

  always_comb begin
    next_state = state;
    next_phase_cnt = phase_cnt;
    next_discard_pending = discard_pending;
    next_clear = 1'b0;
    restart = 1'b0;
    ev_accept = 1'b0;
    ev_miss = 1'b0;
    ev_halt = 1'b0;
    case (state)
      duty_cycle_pkg::ST_OFF: begin
        // [RQ15] idle phase first
        if (enable) begin
          next_state = duty_cycle_pkg::ST_IDLE;
          next_phase_cnt = 8'h0;
          restart = 1'b1;
        end
      end
      duty_cycle_pkg::ST_IDLE: begin
        if (!enable) begin
          // [RQ11] stop on enable cleared
          next_state = duty_cycle_pkg::ST_OFF;
        end else if (idle_tick) begin
          next_phase_cnt = phase_cnt + 8'h1;
          // [RQ8] idle length reached
          if (phase_end) begin
            next_state = duty_cycle_pkg::ST_RX;
            next_phase_cnt = 8'h0;
            restart = 1'b1;
            // [RQ7] discard at receive wake-up
            next_clear = discard_pending;
            next_discard_pending = 1'b0;
          end
        end
      end
      duty_cycle_pkg::ST_RX: begin
        if (accept) begin
          ev_accept = 1'b1;
          // [RQ4] stay in receive; reserved 11 behaves the same
          if (cfg.after_accept_action == duty_cycle_pkg::ACT_STAY_RX ||
              cfg.after_accept_action == 2'h3) begin
            next_state = duty_cycle_pkg::ST_HALT_RX;
            ev_halt = 1'b1;
          end else begin
            next_state = duty_cycle_pkg::ST_WAIT;
          end
        end else if (rx_tick) begin
          next_phase_cnt = phase_cnt + 8'h1;
          // [RQ9] [RQ16] receive length reached without acceptance
          if (phase_end) begin
            ev_miss = 1'b1;
            next_state = enable ? duty_cycle_pkg::ST_IDLE :
              duty_cycle_pkg::ST_OFF;
            next_phase_cnt = 8'h0;
            restart = 1'b1;
          end
        end
      end
      duty_cycle_pkg::ST_WAIT: begin
        if (payload_complete_flag_i || rx_timeout_i) begin
          if (cfg.after_accept_action == duty_cycle_pkg::ACT_RESUME) begin
            // [RQ6] resume idle phase
            next_state = enable ? duty_cycle_pkg::ST_IDLE :
              duty_cycle_pkg::ST_OFF;
            next_phase_cnt = 8'h0;
            restart = 1'b1;
            next_discard_pending = 1'b1;
          end else begin
            // [RQ5] go to programmed mode
            next_state = duty_cycle_pkg::ST_HALT;
            ev_halt = 1'b1;
          end
        end
      end
      duty_cycle_pkg::ST_HALT_RX, duty_cycle_pkg::ST_HALT: begin
        if (!enable) begin
          next_state = duty_cycle_pkg::ST_OFF;
        end
      end
      default: next_state = duty_cycle_pkg::ST_OFF;
    endcase
    // [RQ12] abort terminates at once
    if (abort_req) begin
      next_state = duty_cycle_pkg::ST_OFF;
      next_clear = 1'b0;
    end
    // [RQ13] current chip mode
    case (next_state)
      duty_cycle_pkg::ST_IDLE: next_chip_mode = duty_cycle_pkg::MODE_SLEEP;
      duty_cycle_pkg::ST_RX, duty_cycle_pkg::ST_WAIT,
      duty_cycle_pkg::ST_HALT_RX: next_chip_mode = duty_cycle_pkg::MODE_RX;
      default: next_chip_mode = next_mode_field;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= duty_cycle_pkg::ST_OFF;
      phase_cnt <= 8'h0;
      discard_pending <= 1'b0;
      rx_buffer_clear_o <= 1'b0;
      chip_mode_o <= duty_cycle_pkg::MODE_RESET;
    end else begin
      state <= next_state;
      phase_cnt <= next_phase_cnt;
      discard_pending <= next_discard_pending;
      rx_buffer_clear_o <= next_clear;
      chip_mode_o <= next_chip_mode;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  idle_tick_gate_a: assert property ( // [RQ1]
    state == duty_cycle_pkg::ST_IDLE && enable && !idle_tick && !abort_req
    |=> state == duty_cycle_pkg::ST_IDLE && $stable(phase_cnt))
    else $error("idle count moved without idle tick");
  rx_tick_gate_a: assert property ( // [RQ2]
    state == duty_cycle_pkg::ST_RX && !rx_tick && !accept && !abort_req
    |=> state == duty_cycle_pkg::ST_RX && $stable(phase_cnt))
    else $error("receive phase moved without tick or accept");
  accept_rule_a: assert property ( // [RQ3]
    state == duty_cycle_pkg::ST_RX && cfg.wake_accept_rule &&
    !sync_word_match_i && !abort_req
    |=> state != duty_cycle_pkg::ST_WAIT && state != duty_cycle_pkg::ST_HALT_RX)
    else $error("accepted without sync match");
  stay_rx_a: assert property ( // [RQ4]
    state == duty_cycle_pkg::ST_RX && accept && !abort_req &&
    cfg.after_accept_action == duty_cycle_pkg::ACT_STAY_RX
    |=> state == duty_cycle_pkg::ST_HALT_RX &&
        chip_mode_o == duty_cycle_pkg::MODE_RX)
    else $error("action 00 did not hold receive");
  goto_mode_a: assert property ( // [RQ5]
    state == duty_cycle_pkg::ST_WAIT && !abort_req &&
    cfg.after_accept_action == duty_cycle_pkg::ACT_GOTO_MODE &&
    (payload_complete_flag_i || rx_timeout_i) && $stable(mode_field)
    |=> state == duty_cycle_pkg::ST_HALT && chip_mode_o == mode_field)
    else $error("action 01 did not switch mode");
  resume_idle_a: assert property ( // [RQ6]
    state == duty_cycle_pkg::ST_WAIT && enable && !abort_req &&
    cfg.after_accept_action == duty_cycle_pkg::ACT_RESUME &&
    (payload_complete_flag_i || rx_timeout_i)
    |=> state == duty_cycle_pkg::ST_IDLE && phase_cnt == 8'h0)
    else $error("action 10 did not resume idle");
  discard_pulse_a: assert property ( // [RQ7]
    rx_buffer_clear_o |-> state == duty_cycle_pkg::ST_RX &&
      $past(state) == duty_cycle_pkg::ST_IDLE ##1 !rx_buffer_clear_o)
    else $error("buffer discard outside receive wake-up");
  idle_end_a: assert property ( // [RQ8]
    state == duty_cycle_pkg::ST_IDLE && enable && idle_tick &&
    phase_cnt == idle_len - 8'h1 && idle_len != 8'h0 && !abort_req
    |=> state == duty_cycle_pkg::ST_RX && phase_cnt == 8'h0)
    else $error("idle phase length wrong");
  abort_stop_a: assert property ( // [RQ12]
    abort_req |=> state == duty_cycle_pkg::ST_OFF ##1
      prdata_o[duty_cycle_pkg::OP_ABORT_BIT] == 1'b0)
    else $error("abort did not stop cycling");
  cal_busy_a: assert property ( // [RQ14]
    $rose(cal_busy) |-> cal_busy[*8])
    else $error("calibration ended too early");

  accept_c: cover property (state == duty_cycle_pkg::ST_RX && accept);
  discard_c: cover property (rx_buffer_clear_o);
  halt_c: cover property ($rose(state == duty_cycle_pkg::ST_HALT));
  miss_c: cover property (ev_miss ##1 state == duty_cycle_pkg::ST_IDLE);

endmodule : listen_mode_duty_cycler

/* File: dv/listen_mode_duty_cycler_test.sv */
// Self-checking testbench for the listen-mode duty cycler
`timescale 1ns/1ps
module listen_mode_duty_cycler_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rx_buffer_clear_o, irq_o;
  logic signal_level_above_i = 1'b0;
  logic sync_word_match_i = 1'b0;
  logic payload_complete_flag_i = 1'b0;
  logic rx_timeout_i = 1'b0;
  logic [2:0] chip_mode_o;
  logic [31:0] r, v;
  logic e;
  int errors = 0;
  int samples_checked = 0;
  int seed = 32'hdb27a4b3;
  int n;
  // Register model: index and reset value
  logic [5:0] idxq[$] = '{6'h01, 6'h0a, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h20};
  logic [31:0] expq[$] = '{8'h04, 8'h41, 8'h52, 8'hf5, 8'h20, 8'h13, 8'h00};

  // Short ticks keep every phase a handful of cycles long
  listen_mode_duty_cycler #(.DIV_64US(4), .DIV_4MS(6), .DIV_262MS(9))
    i_listen_mode_duty_cycler (.clk_i, .rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .signal_level_above_i, .sync_word_match_i, .payload_complete_flag_i,
    .rx_timeout_i, .chip_mode_o, .rx_buffer_clear_o, .irq_o);

  always #5 clk_i = ~clk_i;

  // --------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  // Pready and read data are taken at the rising edge ending the access;
  // only the watchdog ends a wait that never gets an answer
  task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {idx, 2'h0};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task rd(input logic [5:0] idx, input logic [31:0] exp, input logic err);
    apb(1'b0, idx, 32'h0);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, err}, "slave error");
  endtask : rd

  task wait_mode(input logic [2:0] m);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (chip_mode_o !== m && n < 3000);
    chk({29'h0, chip_mode_o}, {29'h0, m}, "mode");
    // Return on a rising edge so callers drive inputs there
    @(posedge clk_i);
  endtask : wait_mode

  // Cycles spent in a mode, checked against a window around len*div
  task dur(input logic [2:0] m, input int lo);
    n = 0;
    while (chip_mode_o === m && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk({31'h0, n >= lo && n <= lo + 3}, 32'h1, "phase length");
  endtask : dur

  task pulse_end(input logic use_timeout);
    @(posedge clk_i);
    signal_level_above_i <= 1'b0;
    sync_word_match_i <= 1'b0;
    payload_complete_flag_i <= !use_timeout;
    rx_timeout_i <= use_timeout;
    @(posedge clk_i);
    payload_complete_flag_i <= 1'b0;
    rx_timeout_i <= 1'b0;
  endtask : pulse_end

  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    test_done();
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (idxq[i]) rd(idxq[i], expq[i], 1'b0);
    rd(6'h0c, 32'h0, 1'b1);
    for (int i = 2; i < 5; i++) begin
      v = $random(seed);
      apb(1'b1, idxq[i], v);
      rd(idxq[i], {24'h0, v[7:1], v[0] & (i != 2)}, 1'b0);
    end
    apb(1'b1, 6'h10, $random(seed));
    rd(6'h10, 32'h13, 1'b0);
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, 6'h01, 32'(m << 2));
      rd(6'h01, 32'(m << 2), 1'b0);
    end
    apb(1'b1, 6'h0a, 32'h80);
    rd(6'h0a, 32'h01, 1'b0);
    repeat (1100) @(posedge clk_i);
    rd(6'h0a, 32'h41, 1'b0);
    rd(6'h20, 32'h08, 1'b0);
    $display("registers done");
    apb(1'b1, 6'h0e, 32'h2);
    apb(1'b1, 6'h0f, 32'h2);
    apb(1'b1, 6'h21, 32'hf);
    apb(1'b1, 6'h0d, 32'h52);
    apb(1'b1, 6'h01, 32'h44);
    wait_mode(duty_cycle_pkg::MODE_SLEEP);
    wait_mode(duty_cycle_pkg::MODE_RX);
    signal_level_above_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pulse_end(1'b0);
    wait_mode(duty_cycle_pkg::MODE_STANDBY);
    chk({31'h0, irq_o}, 32'h1, "irq raised");
    rd(6'h20, 32'h05, 1'b0);
    @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
    apb(1'b1, 6'h01, 32'h04);
    $display("goto mode done");
    apb(1'b1, 6'h21, 32'h0);
    apb(1'b1, 6'h0e, 32'h3);
    apb(1'b1, 6'h0d, 32'h6c);
    signal_level_above_i <= 1'b1;
    apb(1'b1, 6'h01, 32'h44);
    wait_mode(duty_cycle_pkg::MODE_RX);
    dur(duty_cycle_pkg::MODE_RX, 11);
    dur(duty_cycle_pkg::MODE_SLEEP, 11);
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    rd(6'h20, 32'h02, 1'b0);
    sync_word_match_i <= 1'b1;
    wait_mode(duty_cycle_pkg::MODE_RX);
    repeat (20) @(posedge clk_i);
    chk({29'h0, chip_mode_o}, 32'h4, "held in receive");
    pulse_end(1'b1);
    wait_mode(duty_cycle_pkg::MODE_SLEEP);
    n = 0;
    repeat (30) begin
      @(negedge clk_i);
      n += (rx_buffer_clear_o === 1'b1);
    end
    chk(32'(n), 32'h1, "buffer discard");
    apb(1'b1, 6'h01, 32'h24);
    @(negedge clk_i);
    chk({29'h0, chip_mode_o}, 32'h1, "abort");
    rd(6'h01, 32'h04, 1'b0);
    $display("resume done");
    apb(1'b0, 6'h20, 32'h0);
    // Slowest ticks on both phases, stay-in-receive action
    apb(1'b1, 6'h0d, 32'hf0);
    signal_level_above_i <= 1'b1;
    apb(1'b1, 6'h01, 32'h44);
    wait_mode(duty_cycle_pkg::MODE_SLEEP);
    dur(duty_cycle_pkg::MODE_SLEEP, 26);
    repeat (40) @(posedge clk_i);
    signal_level_above_i <= 1'b0;
    chk({29'h0, chip_mode_o}, 32'h4, "stay receive");
    rd(6'h20, 32'h05, 1'b0);
    apb(1'b1, 6'h01, 32'h24);
    wait_mode(duty_cycle_pkg::MODE_STANDBY);
    $display("stay done");
    test_done();
  end
endmodule : listen_mode_duty_cycler_test
